// *** src/slmpc_pkg.sv ***
// constants and types for the lane mode and power configuration block
// assumes: 24-bit register addresses, 8-bit registers
package slmpc_pkg;

  // command opcodes (plain defaults)
  localparam logic [7:0] WRITE_ANY_REGISTER_CMD   = 8'h71;
  localparam logic [7:0] READ_ANY_REGISTER_CMD    = 8'h65;
  localparam logic [7:0] READ_DRIVE_SLEEP_CFG_CMD = 8'h45;

  // register addresses, non-volatile and volatile copies
  localparam logic [23:0] ADDR_FIRST_CFG_NV  = 24'h000002;
  localparam logic [23:0] ADDR_FIRST_CFG_V   = 24'h070002;
  localparam logic [23:0] ADDR_IFACE_CFG_NV  = 24'h000003;
  localparam logic [23:0] ADDR_IFACE_CFG_V   = 24'h070003;
  localparam logic [23:0] ADDR_DRIVE_CFG_NV  = 24'h000005;
  localparam logic [23:0] ADDR_DRIVE_CFG_V   = 24'h070005;

  // field positions
  localparam int QUAD_WIDTH_BIT       = 1;
  localparam int FOUR_LANE_BIT        = 6;
  localparam int LANE3_RESET_ALT_BIT  = 5;
  localparam int TWO_LANE_BIT         = 4;
  localparam int DEEP_SLEEP_BIT       = 2;
  localparam int DRIVE_LSB            = 5;
  localparam int DRIVE_MSB            = 7;

  // writable bit masks; other bits read as zero
  localparam logic [7:0] FIRST_CFG_MASK = 8'h02;
  localparam logic [7:0] IFACE_CFG_MASK = 8'h70;
  localparam logic [7:0] DRIVE_CFG_MASK = 8'hec;

  // factory defaults
  localparam logic [7:0] FIRST_CFG_DEF = 8'h00;
  localparam logic [7:0] IFACE_CFG_DEF = 8'h00;
  localparam logic [7:0] DRIVE_CFG_DEF = 8'h08;

  // frame field lengths in bits
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam logic [5:0] DATA_BITS  = 6'h08;

  // protocol mode
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_DUAL,
    MODE_QUAD
  } slmpc_mode_e;

  // link frame phase
  typedef enum logic [2:0] {
    PH_INSTR,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_IGNORE
  } slmpc_phase_e;

  // device power state
  typedef enum logic [1:0] {
    PWR_RESET,
    PWR_STANDBY,
    PWR_DEEP_SLEEP
  } slmpc_pwr_e;

  // protocol selection from the interface config register
  function automatic slmpc_mode_e mode_decode(input logic [7:0] cr2);
    if (cr2[TWO_LANE_BIT] && !cr2[FOUR_LANE_BIT]) begin
      return MODE_DUAL;
    end
    if (!cr2[TWO_LANE_BIT] && cr2[FOUR_LANE_BIT]) begin
      return MODE_QUAD;
    end
    return MODE_SINGLE; // both clear or both set
  endfunction

endpackage

// *** src/slmpc_sync.sv ***
// two flip-flop level synchroniser
// assumes: synchronous active-low reset in the destination domain
`timescale 1ns/10ps
module slmpc_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by q_o

  // two stages, no logic between them
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= RST_VAL[WIDTH-1:0];
      q_o    <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// *** src/slmpc_link.sv ***
// serial link end: instruction, address, write and read data phases
// assumes: serial clock gated by chip select, sample on rising edge,
// config inputs quasi-static (change only between frames)
`timescale 1ns/10ps
module slmpc_link (
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               nrst_i,
  input  wire slmpc_pkg::slmpc_mode_e mode_i,
  input  wire logic [39:0]        regs_i,
  input  wire logic [3:0]         lane_i,
  output logic      [3:0]         lane_o,
  output logic      [3:0]         lane_oe_n_o,
  output logic                    wr_tgl_o,
  output logic      [23:0]        wr_addr_o,
  output logic      [7:0]         wr_data_o
);
  typedef struct packed {
    slmpc_pkg::slmpc_phase_e ph;  // frame phase
    logic [5:0]  cnt;             // bits taken in phase
    logic [23:0] sh;              // input shifter
    logic [7:0]  opc;             // instruction
    logic [7:0]  rd;              // read shifter
    logic [3:0]  lane;            // lane outputs
    logic [3:0]  oe_n;            // lane enables, low drives
    logic        tgl;             // write event toggle
    logic [23:0] waddr;           // write address
    logic [7:0]  wdata;           // write data
  } slmpc_link_s;

  slmpc_link_s s_r, s_nxt;
  logic        fresh_r;           // set while chip select high
  logic [5:0]  w;                 // bits per clock
  logic [5:0]  nb;                // bits after this edge
  logic [23:0] sh_in;             // shifter after this edge

  // register read mux
  function automatic logic [7:0] rd_reg(input logic [23:0] a,
                                        input logic [39:0] r);
    case (a)
      slmpc_pkg::ADDR_FIRST_CFG_NV, slmpc_pkg::ADDR_FIRST_CFG_V: return r[7:0];
      slmpc_pkg::ADDR_IFACE_CFG_NV: return r[15:8];
      slmpc_pkg::ADDR_IFACE_CFG_V:  return r[23:16];
      slmpc_pkg::ADDR_DRIVE_CFG_NV: return r[31:24];
      slmpc_pkg::ADDR_DRIVE_CFG_V:  return r[39:32];
      default: return 8'h00;
    endcase
  endfunction

  // frame start marker, set by chip select without a clock
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // phase sequencing and lane shifting
  always_comb begin
    s_nxt = s_r;
    w     = 6'h01; // single lane; dual and quad widen all phases, instruction too
    case (mode_i)
      slmpc_pkg::MODE_DUAL: w = 6'h02; // lanes 0..1
      slmpc_pkg::MODE_QUAD: w = 6'h04; // lanes 0..3
      default:              w = 6'h01;
    endcase
    if (fresh_r) begin
      s_nxt.ph   = slmpc_pkg::PH_INSTR;
      s_nxt.cnt  = 6'h00;
      s_nxt.oe_n = 4'hf;
    end
    case (w)
      6'h02:   sh_in = {s_r.sh[21:0], lane_i[1:0]};
      6'h04:   sh_in = {s_r.sh[19:0], lane_i[3:0]}; // lane 3 data
      default: sh_in = {s_r.sh[22:0], lane_i[0]};
    endcase
    nb       = s_nxt.cnt + w;
    s_nxt.sh = sh_in;
    s_nxt.cnt = nb;
    case (s_nxt.ph)
      slmpc_pkg::PH_INSTR: begin
        if (nb == slmpc_pkg::INSTR_BITS) begin
          s_nxt.opc = sh_in[7:0];
          s_nxt.cnt = 6'h00;
          s_nxt.ph  = slmpc_pkg::PH_IGNORE;
          if (sh_in[7:0] == slmpc_pkg::WRITE_ANY_REGISTER_CMD ||
              sh_in[7:0] == slmpc_pkg::READ_ANY_REGISTER_CMD) begin
            s_nxt.ph = slmpc_pkg::PH_ADDR;
          end else if (sh_in[7:0] == slmpc_pkg::READ_DRIVE_SLEEP_CFG_CMD) begin
            s_nxt.ph = slmpc_pkg::PH_RDATA;
            s_nxt.rd = regs_i[39:32];
          end
        end
      end
      slmpc_pkg::PH_ADDR: begin
        if (nb == slmpc_pkg::ADDR_BITS) begin
          s_nxt.cnt   = 6'h00;
          s_nxt.waddr = sh_in;
          s_nxt.ph    = slmpc_pkg::PH_RDATA;
          s_nxt.rd    = rd_reg(sh_in, regs_i);
          if (s_r.opc == slmpc_pkg::WRITE_ANY_REGISTER_CMD) begin
            s_nxt.ph = slmpc_pkg::PH_WDATA; // only write path
          end
        end
      end
      slmpc_pkg::PH_WDATA: begin
        if (nb == slmpc_pkg::DATA_BITS) begin
          s_nxt.wdata = sh_in[7:0];
          s_nxt.tgl   = ~s_r.tgl;
          s_nxt.ph    = slmpc_pkg::PH_IGNORE;
        end
      end
      slmpc_pkg::PH_RDATA: begin
        // drive the top bits, then shift; zeros follow the byte
        s_nxt.oe_n = 4'hd; // lane 1 only in single lane
        s_nxt.lane = {2'b00, s_nxt.rd[7], 1'b0};
        if (w == 6'h02) begin
          s_nxt.oe_n = 4'hc;
          s_nxt.lane = {2'b00, s_nxt.rd[7:6]};
        end else if (w == 6'h04) begin
          s_nxt.oe_n = 4'h0; // lane 3 as data only in quad
          s_nxt.lane = s_nxt.rd[7:4];
        end
        s_nxt.rd = 8'(s_nxt.rd << w);
        if (s_r.ph == slmpc_pkg::PH_RDATA && nb >= slmpc_pkg::DATA_BITS) begin
          s_nxt.cnt = 6'h00;
        end
        if (s_r.ph != slmpc_pkg::PH_RDATA || fresh_r) begin
          s_nxt.cnt = 6'h00;
        end
      end
      default: s_nxt.cnt = 6'h00;
    endcase
  end

  // state register, cleared by device reset only
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{ph: slmpc_pkg::PH_INSTR, oe_n: 4'hf, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lane_o      = s_r.lane;
  assign lane_oe_n_o = s_r.oe_n | {4{fresh_r}}; // released at frame end
  assign wr_tgl_o    = s_r.tgl;
  assign wr_addr_o   = s_r.waddr;
  assign wr_data_o   = s_r.wdata;
endmodule

// *** src/slmpc_cfg.sv ***
// lane mode and power configuration: registers, shared pin, reset exit
// assumes: clk_i system clock, sclk_i serial clock from the host,
// bus and soft reset pulses from logic on clk_i
`timescale 1ns/10ps
module slmpc_cfg #(
  parameter logic [7:0] FIRST_CFG_FACTORY = slmpc_pkg::FIRST_CFG_DEF,
  parameter logic [7:0] IFACE_CFG_FACTORY = slmpc_pkg::IFACE_CFG_DEF,
  parameter logic [7:0] DRIVE_CFG_FACTORY = slmpc_pkg::DRIVE_CFG_DEF
) (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic [3:0]             lane_i,
  output logic      [3:0]             lane_o,
  output logic      [3:0]             lane_oe_n_o,
  input  wire logic                   wp_n_i,
  input  wire logic                   bus_reset_i,
  input  wire logic                   soft_reset_i,
  output slmpc_pkg::slmpc_mode_e      mode_o,
  output logic                        ext_quad_cmds_o,
  output logic                        lane3_is_data_o,
  output logic                        lane3_is_reset_o,
  output logic                        wp_level_o,
  output logic      [2:0]             output_drive_select_o,
  output logic                        deep_sleep_o,
  output logic                        standby_o,
  output logic                        in_reset_o
);

  // whole state of the configuration side
  typedef struct packed {
    logic [7:0] cr1;        // first config register
    logic [7:0] cr2_nv;     // interface config, non-volatile
    logic [7:0] cr2_v;      // interface config, volatile
    logic [7:0] cr4_nv;     // drive and sleep, non-volatile
    logic [7:0] cr4_v;      // drive and sleep, volatile
    logic       tgl_seen;   // last write toggle taken
    logic       pin_rst;    // pin reset seen last cycle
    logic       por_pend;   // power-on completion pending
    slmpc_pkg::slmpc_pwr_e pwr; // power state
    slmpc_pkg::slmpc_mode_e mode; // decoded protocol
    logic       ext_quad;   // extended quad commands
    logic       l3_data;    // shared pin is lane 3
    logic       l3_rst;     // shared pin is reset
    logic       wp_lvl;     // effective protect level
    logic [2:0] drive;      // output drive select
  } slmpc_cfg_s;

  slmpc_cfg_s s_r, s_nxt;

  logic [3:0]  sync_q;       // synced: toggle, lane 3, protect, cs
  logic        wr_tgl;       // write toggle from the link
  logic [23:0] wr_addr;      // write address from the link
  logic [7:0]  wr_data;      // write data from the link
  logic        cs_high;      // synced chip select high
  logic        pin_rst_now;  // shared pin asserting reset
  logic        complete;     // a hardware reset just ended
  logic [7:0]  wbits;        // masked write data

  // shared pin acts as reset for this mode and chip select
  function automatic logic lane3_reset_fn(input logic lane3_reset_alternate,
                                          input slmpc_pkg::slmpc_mode_e m,
                                          input logic quad,
                                          input logic csh);
    if (!lane3_reset_alternate) begin
      return 1'b0;                 // no alternate function
    end
    if (csh) begin
      return 1'b1;                 // always reset with cs high
    end
    case (m)
      slmpc_pkg::MODE_QUAD: return 1'b0; // lane 3 instead
      default:              return !quad; // quad width: no function
    endcase
  endfunction

  // shared pin carries lane 3 data
  function automatic logic lane3_data_fn(input slmpc_pkg::slmpc_mode_e m,
                                         input logic quad,
                                         input logic csh);
    if (csh) begin
      return 1'b0;
    end
    case (m)
      slmpc_pkg::MODE_QUAD:   return 1'b1;
      slmpc_pkg::MODE_SINGLE: return quad;  // quad data phases
      default:                return 1'b0;  // never in two-lane
    endcase
  endfunction

  // link end on the serial clock
  slmpc_link u_link (
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .nrst_i      (nrst_i),
    .mode_i      (s_r.mode),
    .regs_i      ({s_r.cr4_v, s_r.cr4_nv, s_r.cr2_v, s_r.cr2_nv, s_r.cr1}),
    .lane_i      (lane_i),
    .lane_o      (lane_o),
    .lane_oe_n_o (lane_oe_n_o),
    .wr_tgl_o    (wr_tgl),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data)
  );

  // bring the toggle and the pins onto clk_i
  slmpc_sync #(
    .WIDTH   (4),
    .RST_VAL (8'h07)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({wr_tgl, lane_i[3], wp_n_i, cs_n_i}),
    .q_o    (sync_q)
  );

  // next-state logic
  always_comb begin
    s_nxt       = s_r;
    cs_high     = sync_q[0];
    pin_rst_now = s_r.l3_rst && !sync_q[2];      // active low
    complete    = 1'b0;
    wbits       = 8'h00;

    // register write arriving from the link
    if (sync_q[3] != s_r.tgl_seen) begin
      s_nxt.tgl_seen = sync_q[3];
      if (s_r.pwr != slmpc_pkg::PWR_RESET) begin
        case (wr_addr)
          slmpc_pkg::ADDR_FIRST_CFG_NV, slmpc_pkg::ADDR_FIRST_CFG_V: begin
            s_nxt.cr1 = wr_data & slmpc_pkg::FIRST_CFG_MASK;
          end
          slmpc_pkg::ADDR_IFACE_CFG_NV: begin
            wbits = wr_data & slmpc_pkg::IFACE_CFG_MASK;
            s_nxt.cr2_nv = wbits;
            s_nxt.cr2_v  = wbits;
          end
          slmpc_pkg::ADDR_IFACE_CFG_V: begin
            s_nxt.cr2_v = wr_data & slmpc_pkg::IFACE_CFG_MASK;
          end
          slmpc_pkg::ADDR_DRIVE_CFG_NV: begin
            wbits = wr_data & slmpc_pkg::DRIVE_CFG_MASK; // bit 3 kept
            s_nxt.cr4_nv = wbits;
            s_nxt.cr4_v  = wbits;
          end
          slmpc_pkg::ADDR_DRIVE_CFG_V: begin
            s_nxt.cr4_v = wr_data & slmpc_pkg::DRIVE_CFG_MASK;
          end
          default: wbits = 8'h00; // unmapped, dropped
        endcase
      end
    end

    // reset sources, highest priority last
    if (soft_reset_i) begin
      s_nxt.cr2_v = s_r.cr2_nv;
      s_nxt.cr4_v = s_r.cr4_nv;
      s_nxt.pwr   = slmpc_pkg::PWR_STANDBY; // sleep bit ignored
    end
    if (s_r.por_pend || bus_reset_i) begin
      s_nxt.por_pend = 1'b0;
      complete       = 1'b1;
    end
    if (s_r.pin_rst && !pin_rst_now) begin
      complete = 1'b1;                     // pin reset released
    end
    if (complete) begin
      s_nxt.cr2_v = s_r.cr2_nv;
      s_nxt.cr4_v = s_r.cr4_nv;
      s_nxt.pwr   = slmpc_pkg::PWR_STANDBY;
      if (s_r.cr4_nv[slmpc_pkg::DEEP_SLEEP_BIT] && cs_high) begin
        s_nxt.pwr = slmpc_pkg::PWR_DEEP_SLEEP;
      end
    end
    if (pin_rst_now) begin
      s_nxt.pwr = slmpc_pkg::PWR_RESET;      // held while pin low
    end
    s_nxt.pin_rst = pin_rst_now;

    // decoded views of the volatile registers
    s_nxt.mode     = slmpc_pkg::mode_decode(s_nxt.cr2_v);
    s_nxt.ext_quad = (s_nxt.mode == slmpc_pkg::MODE_SINGLE) &&
                     s_nxt.cr1[slmpc_pkg::QUAD_WIDTH_BIT];
    s_nxt.l3_rst   = lane3_reset_fn(s_nxt.cr2_v[slmpc_pkg::LANE3_RESET_ALT_BIT],
                                    s_nxt.mode,
                                    s_nxt.cr1[slmpc_pkg::QUAD_WIDTH_BIT],
                                    cs_high);
    s_nxt.l3_data  = lane3_data_fn(s_nxt.mode,
                                   s_nxt.cr1[slmpc_pkg::QUAD_WIDTH_BIT],
                                   cs_high);
    // protect input held at one once its pin is a lane
    s_nxt.wp_lvl   = sync_q[1];
    if (s_nxt.cr1[slmpc_pkg::QUAD_WIDTH_BIT] ||
        s_nxt.mode == slmpc_pkg::MODE_QUAD) begin
      s_nxt.wp_lvl = 1'b1;
    end
    s_nxt.drive = s_nxt.cr4_v[slmpc_pkg::DRIVE_MSB:slmpc_pkg::DRIVE_LSB];
  end

  // state register; reset loads factory values
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '{cr1:      FIRST_CFG_FACTORY,
               cr2_nv:   IFACE_CFG_FACTORY,
               cr2_v:    IFACE_CFG_FACTORY,
               cr4_nv:   DRIVE_CFG_FACTORY,
               cr4_v:    DRIVE_CFG_FACTORY,
               por_pend: 1'b1,
               pwr:      slmpc_pkg::PWR_RESET,
               mode:     slmpc_pkg::MODE_SINGLE,
               wp_lvl:   1'b1,
               default:  '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign mode_o                = s_r.mode;
  assign ext_quad_cmds_o       = s_r.ext_quad;
  assign lane3_is_data_o       = s_r.l3_data;
  assign lane3_is_reset_o      = s_r.l3_rst;
  assign wp_level_o            = s_r.wp_lvl;
  assign output_drive_select_o = s_r.drive;
  assign deep_sleep_o          = (s_r.pwr == slmpc_pkg::PWR_DEEP_SLEEP);
  assign standby_o             = (s_r.pwr == slmpc_pkg::PWR_STANDBY);
  assign in_reset_o            = (s_r.pwr == slmpc_pkg::PWR_RESET);
endmodule

// *** verif/slmpc_cfg_properties.sv ***
// port checker for the lane mode and power configuration block
// assumes: bound to slmpc_cfg, all checks on clk_i
`timescale 1ns/10ps
module slmpc_cfg_properties (
  input wire logic                   clk_i,
  input wire logic                   nrst_i,
  input wire logic                   cs_n_i,
  input wire logic [3:0]             lane_i,
  input wire logic [3:0]             lane_oe_n_o,
  input wire logic                   bus_reset_i,
  input wire logic                   soft_reset_i,
  input wire slmpc_pkg::slmpc_mode_e mode_o,
  input wire logic                   ext_quad_cmds_o,
  input wire logic                   lane3_is_data_o,
  input wire logic                   lane3_is_reset_o,
  input wire logic                   wp_level_o,
  input wire logic [2:0]             output_drive_select_o,
  input wire logic                   deep_sleep_o,
  input wire logic                   standby_o,
  input wire logic                   in_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire ev = bus_reset_i | soft_reset_i | !lane_i[3]; // any reset cause
  a_oe_idle: assert property (cs_n_i && $past(cs_n_i) |-> lane_oe_n_o == 4'hf)
    else $error("lanes driven while deselected");
  a_ext_single: assert property (ext_quad_cmds_o |-> mode_o == slmpc_pkg::MODE_SINGLE)
    else $error("extended quad outside single mode");
  a_quad_wp: assert property (mode_o == slmpc_pkg::MODE_QUAD |-> wp_level_o)
    else $error("protect level low in quad");
  a_dual_lane3: assert property (mode_o == slmpc_pkg::MODE_DUAL |-> !lane3_is_data_o)
    else $error("lane 3 data in dual mode");
  a_reset_alt: assert property (lane3_is_reset_o |-> !lane3_is_data_o)
    else $error("shared pin has two roles");
  a_pwr_onehot: assert property ($onehot({deep_sleep_o, standby_o, in_reset_o}))
    else $error("power state not one-hot");
  a_factory_vals: assert property ($rose(nrst_i) |-> in_reset_o && wp_level_o &&
    mode_o == slmpc_pkg::MODE_SINGLE && output_drive_select_o == 3'h0)
    else $error("wrong state during reset");
  a_soft_standby: assert property (soft_reset_i |-> ##[1:8] standby_o)
    else $error("soft reset missed standby");
  a_sleep_hold: assert property (deep_sleep_o && !ev && !$past(ev) && !$past(ev, 2)
    && !$past(ev, 3) |=> deep_sleep_o)
    else $error("left deep sleep without reset");
  a_pin_reset: assert property (cs_n_i && $past(cs_n_i) && lane3_is_reset_o && !lane_i[3]
    |-> ##[1:4] in_reset_o)
    else $error("pin reset not taken");
  c_deep: cover property (deep_sleep_o);
  c_quad: cover property (mode_o == slmpc_pkg::MODE_QUAD);
  c_pin: cover property (lane3_is_reset_o && in_reset_o);
endmodule

// *** verif/slmpc_host.sv ***
// serial bus host model, mode 0, 160 ns serial clock only within frames
// assumes: device samples on sclk rise; released lanes pulled high
`timescale 1ns/10ps
module slmpc_host (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] lane_o,
  input  wire  [3:0] lane_i
);
  int         w   = 1;    // bits per clock
  logic       pin = 1'b1; // shared reset pin level
  logic       drv = 1'b0; // host drives lanes
  logic [3:0] dat = 4'hf; // driven lane values
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  assign lane_o = drv ? dat : {pin, 3'b111};
  // one frame: opcode, optional address, write or read byte
  task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input logic na,
                      input logic [7:0] wd, input logic nw, output logic [7:0] rd);
    logic [39:0] sh;
    int          nb, k, j;
    sh = na ? {op, ad, wd} : {op, wd, 24'h0};
    nb = 8 + (na ? 24 : 0) + (nw ? 8 : 0);
    rd = 8'h00;
    #3 cs_n_o = 1'b0;
    drv = 1'b1;
    dat = 4'hf;
    for (k = 0; k < nb; k += w) begin
      for (j = 0; j < w; j++) dat[w-1-j] = sh[39-j];
      sh = sh << w;
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    drv = 1'b0;
    for (k = 0; k < (nw ? 0 : 8); k += w) begin
      #80 sclk_o = 1'b1; // device launches read bits on this rise
      #40;
      for (j = 0; j < w; j++) rd = {rd[6:0], (w == 1) ? lane_i[1] : lane_i[w-1-j]};
      #40 sclk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    #160;
  endtask
endmodule

// *** verif/serial_lane_mode_and_power_config_test.sv ***
// testbench for slmpc_cfg with a host model on the serial link
// assumes: slmpc_host frames; clk_i inputs change at falling edge
`timescale 1ns/10ps
module serial_lane_mode_and_power_config_test;
  logic clk_i = 1'b0, nrst_i = 1'b0, bus_reset_i = 1'b0, soft_reset_i = 1'b0, wp_n_i = 1'b1;
  wire        sclk_i, cs_n_i;
  wire  [3:0] lane_i;
  logic [3:0] lane_o, lane_oe_n_o;
  logic       ext_quad_cmds_o, lane3_is_data_o, lane3_is_reset_o, wp_level_o;
  logic       deep_sleep_o, standby_o, in_reset_o, q;
  logic [2:0] output_drive_select_o;
  logic [7:0] d, rd, c2;
  int         fails = 0, n_checks = 0, seed = 32'h7944, i;
  logic [31:0] r;
  slmpc_pkg::slmpc_mode_e mode_o, m;
  always #5 clk_i = ~clk_i;
  slmpc_cfg slmpc_cfg_i (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .lane_i(lane_i), .lane_o(lane_o), .lane_oe_n_o(lane_oe_n_o), .wp_n_i(wp_n_i),
    .bus_reset_i(bus_reset_i), .soft_reset_i(soft_reset_i), .mode_o(mode_o),
    .ext_quad_cmds_o(ext_quad_cmds_o), .lane3_is_data_o(lane3_is_data_o),
    .lane3_is_reset_o(lane3_is_reset_o), .wp_level_o(wp_level_o),
    .output_drive_select_o(output_drive_select_o), .deep_sleep_o(deep_sleep_o),
    .standby_o(standby_o), .in_reset_o(in_reset_o));
  // undriven lanes are pulled high on the way back to the host
  slmpc_host slmpc_host_i (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .lane_o(lane_i),
    .lane_i(lane_o | lane_oe_n_o));
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v({7'h0, g}, {7'h0, e});
  endtask
  // expected protocol from the enable bits
  function automatic slmpc_pkg::slmpc_mode_e exp_mode(input logic [7:0] c);
    case ({c[6], c[4]})
      2'b10:   return slmpc_pkg::MODE_QUAD;
      2'b01:   return slmpc_pkg::MODE_DUAL;
      default: return slmpc_pkg::MODE_SINGLE;
    endcase
  endfunction
  task automatic wr(input logic [23:0] a, input logic [7:0] v);
    slmpc_host_i.xfer(slmpc_pkg::WRITE_ANY_REGISTER_CMD, a, 1'b1, v, 1'b1, rd);
  endtask
  task automatic rdr(input logic [23:0] a, output logic [7:0] v);
    slmpc_host_i.xfer(slmpc_pkg::READ_ANY_REGISTER_CMD, a, 1'b1, 8'h00, 1'b0, v);
  endtask
  // bounded wait for reset to finish
  task automatic wait_run;
    for (int k = 0; k < 40 && in_reset_o !== 1'b0; k++) @(negedge clk_i);
    if (in_reset_o !== 1'b0) begin
      fails++;
      finish_test;
    end
  endtask
  // one-cycle reset pulse: 0 bus, 1 soft
  task automatic pulse(input logic s);
    @(negedge clk_i);
    if (s) soft_reset_i = 1'b1;
    else bus_reset_i = 1'b1;
    @(negedge clk_i);
    {bus_reset_i, soft_reset_i} = 2'b00;
    repeat (4) @(negedge clk_i);
    wait_run;
  endtask
  initial begin
    #500000;
    fails++;
    finish_test;
  end
  initial begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    wait_run;
    chk_b(standby_o, 1'b1);
    chk_v({5'h0, output_drive_select_o}, 8'h00);
    rdr(slmpc_pkg::ADDR_DRIVE_CFG_NV, d);
    chk_v(d, 8'h08);
    $display("factory test done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      d = {r[2:0], 5'h08};
      wr(i[0] ? slmpc_pkg::ADDR_DRIVE_CFG_V : slmpc_pkg::ADDR_DRIVE_CFG_NV, d);
      slmpc_host_i.xfer(slmpc_pkg::READ_DRIVE_SLEEP_CFG_CMD, 24'h0, 1'b0, 8'h00, 1'b0, rd);
      chk_v(rd, d);
      chk_v({5'h0, output_drive_select_o}, {5'h0, d[7:5]});
    end
    wr(24'h000004, 8'hff);
    rdr(slmpc_pkg::ADDR_DRIVE_CFG_V, rd);
    chk_v(rd, d);
    wr(slmpc_pkg::ADDR_DRIVE_CFG_V, 8'hff);
    rdr(slmpc_pkg::ADDR_DRIVE_CFG_V, rd);
    chk_v(rd, 8'hec);
    $display("drive test done");
    wr(slmpc_pkg::ADDR_DRIVE_CFG_NV, 8'h0c);
    pulse(1'b0);
    chk_b(deep_sleep_o, 1'b1);
    pulse(1'b1);
    chk_b(standby_o, 1'b1);
    wr(slmpc_pkg::ADDR_DRIVE_CFG_NV, 8'h08);
    pulse(1'b0);
    chk_b(standby_o, 1'b1);
    $display("sleep test done");
    for (i = 1; i < 5; i++) begin
      r = $random(seed);
      q = r[0];
      @(negedge clk_i);
      wp_n_i = r[1];
      c2 = {1'b0, i[1], 1'b0, i[0], 4'h0};
      m = exp_mode(c2);
      wr(slmpc_pkg::ADDR_FIRST_CFG_V, {6'h0, q, 1'b0});
      wr(slmpc_pkg::ADDR_IFACE_CFG_V, c2);
      slmpc_host_i.w = (m == slmpc_pkg::MODE_QUAD) ? 4 : (m == slmpc_pkg::MODE_DUAL) ? 2 : 1;
      chk_v({6'h0, mode_o}, {6'h0, m});
      chk_b(ext_quad_cmds_o, m == slmpc_pkg::MODE_SINGLE && q);
      chk_b(wp_level_o, q || m == slmpc_pkg::MODE_QUAD || wp_n_i);
      chk_b(lane3_is_data_o, 1'b0);
      rdr(slmpc_pkg::ADDR_IFACE_CFG_V, rd);
      chk_v(rd, c2);
    end
    $display("mode test done");
    wr(slmpc_pkg::ADDR_IFACE_CFG_V, 8'h20);
    chk_b(lane3_is_reset_o, 1'b1);
    slmpc_host_i.pin = 1'b0;
    repeat (6) @(negedge clk_i);
    chk_b(in_reset_o, 1'b1);
    slmpc_host_i.pin = 1'b1;
    repeat (4) @(negedge clk_i);
    wait_run;
    chk_b(standby_o, 1'b1);
    chk_b(lane3_is_reset_o, 1'b0);
    $display("pin reset test done");
    finish_test;
  end
endmodule
bind slmpc_cfg slmpc_cfg_properties slmpc_cfg_properties_i (.clk_i(clk_i), .nrst_i(nrst_i),
  .cs_n_i(cs_n_i), .lane_i(lane_i), .lane_oe_n_o(lane_oe_n_o), .bus_reset_i(bus_reset_i),
  .soft_reset_i(soft_reset_i), .mode_o(mode_o), .ext_quad_cmds_o(ext_quad_cmds_o),
  .lane3_is_data_o(lane3_is_data_o), .lane3_is_reset_o(lane3_is_reset_o),
  .wp_level_o(wp_level_o), .output_drive_select_o(output_drive_select_o),
  .deep_sleep_o(deep_sleep_o), .standby_o(standby_o), .in_reset_o(in_reset_o));
